// *** include/wdt_regs.svh ***
// register offsets, field positions, reset values and timing counts of the watchdog block
// What this block does
// R1: load permit selects written count, else timeout
// R2: load permit self-clears, cleared by software reset
// R3: count in 23:16, reloaded on re-arm
// R4: expiry raises firmware interrupt and output pin
// R5: expired count stays zero until re-armed
// R6: timeout 31:24 in seconds, resets to 2
// R7: software keeps timeout at least two seconds
// R8: device-functional write re-arms, self-clears
// R9: force-expiry write expires now, zeroes count
// R10: stuck-reason byte 31:24 for firmware, zero functional
// R11: timer microseconds 9:0, milliseconds 19:10
// R12: timer seconds in 31:20, up to 4095
// R13: timer cleared by bus or software reset
// R14: timer written only for test purposes
// R15: enabled nonzero count decrements each second
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH
`define WDT_SETUP_OFFSET 16'h1040
`define WDT_SWSTS_OFFSET 16'h1044
`define WDT_FRT_OFFSET 16'h1048
`define WDT_ENABLE_BIT 0
`define WDT_LOAD_PERMIT_BIT 1
`define WDT_COUNT_LSB 16
`define WDT_COUNT_MSB 23
`define WDT_TIMEOUT_LSB 24
`define WDT_TIMEOUT_MSB 31
`define WDT_TIMEOUT_RESET 8'h02
`define WDT_FUNCTIONAL_BIT 0
`define WDT_FORCE_BIT 1
`define WDT_STUCK_LSB 24
`define WDT_STUCK_MSB 31
`define WDT_US_LSB 0
`define WDT_US_MSB 9
`define WDT_MS_LSB 10
`define WDT_MS_MSB 19
`define WDT_SEC_LSB 20
`define WDT_SEC_MSB 31
`define WDT_CLK_MHZ 200
`define WDT_US_NS 1000
`define WDT_CLK_NS 5
`define WDT_CYCLES_PER_US (`WDT_US_NS / `WDT_CLK_NS)
`define WDT_SUBUNITS 1000
`endif

// *** include/wdt_pkg.sv ***
// types shared by the watchdog block
package wdt_pkg;
   typedef enum logic [1:0] {
      wd_idle,
      wd_run,
      wd_expired
   } wd_state_type;
   typedef logic [7:0] wd_byte_type;
endpackage

// *** rtl/wdt_subcount.sv ***
// modulo counter used for microsecond and millisecond steps
`timescale 1ns/1ps
module wdt_subcount #(
   parameter int WIDTH = 10,
   parameter int MODULUS = 1000
) (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic clear_in,
   input wire logic load_in,
   input wire logic [WIDTH-1:0] load_value_in,
   input wire logic step_in,
   output logic [WIDTH-1:0] count_out,
   output logic wrap_out
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

   assign wrap_out = step_in && (count_q == LAST);
   assign count_out = count_q;

   always_comb begin
      count_d = count_q;
      if (clear_in) begin
         count_d = '0;
      end else if (load_in) begin
         count_d = load_value_in;
      end else if (wrap_out) begin
         count_d = '0;
      end else if (step_in) begin
         count_d = count_q + WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// *** rtl/wdt_sync.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module wdt_sync (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// *** rtl/wdt_top.sv ***
// watchdog with free-running microsecond, millisecond and second timer
`timescale 1ns/1ps
`include "wdt_regs.svh"
module wdt_top (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic bus_reset_n_in,
   input wire logic sw_reset_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic fw_irq_out,
   output logic dedicated_output_pin_out
);
   import wdt_pkg::*;

   // ****************************************
   // pin synchronisation
   // ****************************************
   logic bus_reset_n_s;
   logic bus_reset_pulse;

   wdt_sync bus_reset_sync (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .async_in(bus_reset_n_in),
      .sync_out(bus_reset_n_s)
   );

   assign bus_reset_pulse = !bus_reset_n_s; // R13

   // ****************************************
   // register decode
   // ****************************************
   function automatic logic hit(input logic [15:0] addr, input logic [15:0] offset);
      hit = (addr == offset);
   endfunction

   logic wr_setup;
   logic wr_swsts;
   logic wr_frt;
   logic rd_setup;
   logic rd_swsts;
   logic rd_frt;

   assign wr_setup = reg_wr_in && hit(reg_addr_in, `WDT_SETUP_OFFSET);
   assign wr_swsts = reg_wr_in && hit(reg_addr_in, `WDT_SWSTS_OFFSET);
   assign wr_frt = reg_wr_in && hit(reg_addr_in, `WDT_FRT_OFFSET);

   // ****************************************
   // read strobes
   // ****************************************
   assign rd_setup = reg_rd_in && hit(reg_addr_in, `WDT_SETUP_OFFSET);
   assign rd_swsts = reg_rd_in && hit(reg_addr_in, `WDT_SWSTS_OFFSET);
   assign rd_frt = reg_rd_in && hit(reg_addr_in, `WDT_FRT_OFFSET);

   // ****************************************
   // free-running timer
   // ****************************************
   localparam logic [7:0] CYC_LAST = 8'(`WDT_CYCLES_PER_US - 1);
   logic [7:0] cyc_q;
   logic [7:0] cyc_d;
   logic us_tick;
   logic ms_tick;
   logic sec_tick;
   logic frt_clear;
   logic [9:0] us_count;
   logic [9:0] ms_count;
   logic [11:0] sec_q;
   logic [11:0] sec_d;

   assign frt_clear = bus_reset_pulse || sw_reset_in; // R13
   assign us_tick = (cyc_q == CYC_LAST);

   // ****************************************
   // microsecond prescaler
   // ****************************************
   always_comb begin
      cyc_d = cyc_q + 8'h01;
      if (frt_clear || wr_frt || us_tick) begin
         cyc_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cyc_q <= 8'h00;
      end else begin
         cyc_q <= cyc_d;
      end
   end

   wdt_subcount #(.WIDTH(10), .MODULUS(`WDT_SUBUNITS)) us_counter (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .clear_in(frt_clear),
      .load_in(wr_frt),
      .load_value_in(reg_wdata_in[`WDT_US_MSB:`WDT_US_LSB]),
      .step_in(us_tick),
      .count_out(us_count),
      .wrap_out(ms_tick)
   ); // R11

   wdt_subcount #(.WIDTH(10), .MODULUS(`WDT_SUBUNITS)) ms_counter (
      .core_clk_in(core_clk_in),
      .arst_n_in(arst_n_in),
      .clear_in(frt_clear),
      .load_in(wr_frt),
      .load_value_in(reg_wdata_in[`WDT_MS_MSB:`WDT_MS_LSB]),
      .step_in(ms_tick),
      .count_out(ms_count),
      .wrap_out(sec_tick)
   ); // R11

   // ****************************************
   // seconds field
   // ****************************************
   always_comb begin
      sec_d = sec_q;
      if (frt_clear) begin
         sec_d = 12'h000; // R13
      end else if (wr_frt) begin
         sec_d = reg_wdata_in[`WDT_SEC_MSB:`WDT_SEC_LSB]; // R14
      end else if (sec_tick && sec_q != 12'hfff) begin
         sec_d = sec_q + 12'h001; // R12
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sec_q <= 12'h000;
      end else begin
         sec_q <= sec_d;
      end
   end

   // ****************************************
   // watchdog
   // ****************************************
   wd_state_type state_q;
   wd_state_type state_d;
   logic enable_q;
   logic enable_d;
   logic load_permit_q;
   logic load_permit_d;
   wd_byte_type timeout_q;
   wd_byte_type timeout_d;
   wd_byte_type count_q;
   wd_byte_type count_d;
   wd_byte_type stuck_q;
   wd_byte_type stuck_d;
   wd_byte_type setup_count;
   logic irq_q;
   logic irq_d;
   logic rearm;
   logic force_exp;

   // ****************************************
   // watchdog strobes
   // ****************************************
   assign rearm = wr_swsts && reg_wdata_in[`WDT_FUNCTIONAL_BIT]; // R8
   assign force_exp = wr_swsts && reg_wdata_in[`WDT_FORCE_BIT]; // R9
   assign setup_count = load_permit_q ? reg_wdata_in[`WDT_COUNT_MSB:`WDT_COUNT_LSB]
                                      : reg_wdata_in[`WDT_TIMEOUT_MSB:`WDT_TIMEOUT_LSB]; // R1

   // ****************************************
   // watchdog control fields
   // ****************************************
   always_comb begin
      enable_d = enable_q;
      load_permit_d = load_permit_q;
      timeout_d = timeout_q;
      stuck_d = stuck_q;
      if (wr_setup) begin
         enable_d = reg_wdata_in[`WDT_ENABLE_BIT];
         timeout_d = reg_wdata_in[`WDT_TIMEOUT_MSB:`WDT_TIMEOUT_LSB]; // R6
         if (load_permit_q) begin
            load_permit_d = 1'b0; // R2
         end else begin
            load_permit_d = reg_wdata_in[`WDT_LOAD_PERMIT_BIT];
         end
      end
      if (wr_swsts) begin
         stuck_d = reg_wdata_in[`WDT_STUCK_MSB:`WDT_STUCK_LSB]; // R10
      end
      if (sw_reset_in) begin
         load_permit_d = 1'b0; // R2
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_q <= 1'b0;
         load_permit_q <= 1'b0;
         timeout_q <= `WDT_TIMEOUT_RESET;
         stuck_q <= 8'h00;
      end else begin
         enable_q <= enable_d;
         load_permit_q <= load_permit_d;
         timeout_q <= timeout_d;
         stuck_q <= stuck_d;
      end
   end

   // ****************************************
   // watchdog count and expiry
   // ****************************************
   always_comb begin
      count_d = count_q;
      state_d = state_q;
      case (state_q)
         wd_idle: begin
            if (wr_setup) begin
               count_d = setup_count; // R1
               state_d = wd_run;
            end
         end
         wd_run: begin
            if (wr_setup) begin
               count_d = setup_count; // R1
            end else if (enable_q && (count_q == 8'h00 || (sec_tick && count_q == 8'h01))) begin
               count_d = 8'h00; // R15
               state_d = wd_expired; // R4
            end else if (enable_q && sec_tick) begin
               count_d = count_q - 8'h01; // R15
            end
         end
         wd_expired: begin
            count_d = 8'h00; // R5
         end
         default: begin
            state_d = wd_idle;
         end
      endcase
      if (rearm) begin
         count_d = timeout_d; // R3
         state_d = wd_run;
      end
      if (force_exp) begin
         count_d = 8'h00; // R9
         state_d = wd_expired;
      end
      irq_d = (state_d == wd_expired); // R4
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= wd_idle;
         count_q <= `WDT_TIMEOUT_RESET;
         irq_q <= 1'b0;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
         irq_q <= irq_d;
      end
   end

   // ****************************************
   // watchdog outputs
   // ****************************************
   assign fw_irq_out = irq_q; // R4
   assign dedicated_output_pin_out = irq_q; // R4

   // ****************************************
   // read data
   // ****************************************
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] setup_view;
   logic [31:0] swsts_view;
   logic [31:0] frt_view;

   // ****************************************
   // register views
   // ****************************************
   assign setup_view = {timeout_q, count_q, 14'h0000, load_permit_q, enable_q}; // R3
   assign swsts_view = {stuck_q, 24'h000000}; // R8 R9
   assign frt_view = {sec_q, ms_count, us_count}; // R11 R12

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_setup) begin
         rdata_d = setup_view;
      end else if (rd_swsts) begin
         rdata_d = swsts_view;
      end else if (rd_frt) begin
         rdata_d = frt_view;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;
endmodule

// *** tb/wdt_monitor.sv ***
// assertion checker on the watchdog block ports
`timescale 1ns/1ps
module wdt_monitor (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic bus_reset_n_in,
   input wire logic sw_reset_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic fw_irq_out,
   input wire logic dedicated_output_pin_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire st_wr = reg_wr_in && reg_addr_in == 16'h1044;
   wire su_rd = reg_rd_in && reg_addr_in == 16'h1040;
   wire st_rd = reg_rd_in && reg_addr_in == 16'h1044;
   wire ft_rd = reg_rd_in && reg_addr_in == 16'h1048;
   property p_pin;
      dedicated_output_pin_out == fw_irq_out;
   endproperty
   a_pin: assert property (p_pin) else $error("pin differs from irq");
   property p_force;
      st_wr && reg_wdata_in[1] |-> ##[1:2] fw_irq_out;
   endproperty
   a_force: assert property (p_force) else $error("force did not expire");
   property p_rearm;
      st_wr && reg_wdata_in[1:0] == 2'b01 |=> !fw_irq_out;
   endproperty
   a_rearm: assert property (p_rearm) else $error("re-arm left irq high");
   property p_stuck;
      fw_irq_out && !(st_wr && reg_wdata_in[0]) |=> fw_irq_out;
   endproperty
   a_stuck: assert property (p_stuck) else $error("irq dropped without re-arm");
   property p_sc;
      st_rd |=> reg_rdata_out[23:0] == 24'h0;
   endproperty
   a_sc: assert property (p_sc) else $error("status low bits not zero");
   property p_zero;
      fw_irq_out && su_rd && !reg_wr_in |=> reg_rdata_out[23:16] == 8'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("expired count not zero");
   property p_timer;
      ft_rd |=> reg_rdata_out[9:0] < 10'h3e8 && reg_rdata_out[19:10] < 10'h3e8;
   endproperty
   a_timer: assert property (p_timer) else $error("timer subfield out of range");
   property p_swr;
      sw_reset_in ##1 !reg_wr_in ##1 ft_rd |=> reg_rdata_out[31:10] == 22'h0;
   endproperty
   a_swr: assert property (p_swr) else $error("timer not cleared by sw reset");
   property p_bus;
      !bus_reset_n_in [*4] ##0 ft_rd |=> reg_rdata_out == 32'h0;
   endproperty
   a_bus: assert property (p_bus) else $error("timer not cleared by bus reset");
   property p_perm;
      sw_reset_in ##1 !reg_wr_in ##1 su_rd |=> !reg_rdata_out[1];
   endproperty
   a_perm: assert property (p_perm) else $error("permit survived sw reset");
endmodule
bind wdt_top wdt_monitor wdt_monitor_i (.core_clk_in, .arst_n_in, .bus_reset_n_in,
   .sw_reset_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out,
   .fw_irq_out, .dedicated_output_pin_out);

// *** tb/wdt_host.sv ***
// host software model on the register bus
`timescale 1ns/1ps
module wdt_host (
   input wire logic core_clk_in,
   output logic [15:0] reg_addr_out,
   output logic reg_wr_out,
   output logic [31:0] reg_wdata_out,
   output logic reg_rd_out,
   input wire logic [31:0] reg_rdata_in
);
   initial begin
      reg_addr_out = 16'h0;
      reg_wr_out = 1'b0;
      reg_wdata_out = 32'h0;
      reg_rd_out = 1'b0;
   end
   // timer writes are issued by the bench for test only
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk_in) #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(posedge core_clk_in) #1;
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge core_clk_in) #1;
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(posedge core_clk_in) #1;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
   endtask
endmodule

// *** tb/wdt_top_tb_top.sv ***
// testbench for the watchdog block
`timescale 1ns/1ps
module wdt_top_tb_top;
   typedef struct packed {
      logic w;
      logic [15:0] a;
      logic [31:0] d;
   } row_type;
   logic clk;
   logic arst_n;
   logic bus_rst_n;
   logic sw_rst;
   logic [15:0] addr;
   logic wr;
   logic rd;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic irq;
   logic pin;
   logic [31:0] v;
   int n_mismatch;
   int n_tests;
   row_type rows [10];
   wdt_host wdt_host_i (.core_clk_in(clk), .reg_addr_out(addr), .reg_wr_out(wr),
      .reg_wdata_out(wdata), .reg_rd_out(rd), .reg_rdata_in(rdata));
   wdt_top wdt_top_i (.core_clk_in(clk), .arst_n_in(arst_n), .bus_reset_n_in(bus_rst_n),
      .sw_reset_in(sw_rst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .fw_irq_out(irq),
      .dedicated_output_pin_out(pin));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hffff_ffff);
      wdt_host_i.rd(a, v);
      chk(n, e, v & m);
   endtask
   task automatic pulse();
      @(posedge clk) #1;
      sw_rst = 1'b1;
      @(posedge clk) #1;
      sw_rst = 1'b0;
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      arst_n = 1'b0;
      bus_rst_n = 1'b1;
      sw_rst = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      rows = '{'{1'b0, 16'h1040, 32'h0202_0000}, '{1'b0, 16'h1044, 32'h0},
         '{1'b1, 16'h2000, 32'hffff_ffff}, '{1'b0, 16'h2000, 32'h0},
         '{1'b1, 16'h1044, 32'h5a00_0000}, '{1'b0, 16'h1044, 32'h5a00_0000},
         '{1'b1, 16'h1040, 32'h0500_0002}, '{1'b0, 16'h1040, 32'h0505_0002},
         '{1'b1, 16'h1040, 32'h0509_0000}, '{1'b0, 16'h1040, 32'h0509_0000}};
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wdt_host_i.wr(rows[i].a, rows[i].d);
         end else begin
            rchk("row", rows[i].a, rows[i].d);
         end
      end
      wdt_host_i.wr(16'h1040, 32'h0500_0002);
      pulse();
      rchk("permit", 16'h1040, 32'h0505_0000);
      wdt_host_i.wr(16'h1048, 32'h003f_9fe7);
      repeat (300) @(posedge clk);
      rchk("timer", 16'h1048, 32'h0040_0000, 32'hffff_fc00);
      wdt_host_i.wr(16'h1048, 32'hffff_9fe7);
      repeat (300) @(posedge clk);
      rchk("saturate", 16'h1048, 32'hfff0_0000, 32'hffff_fc00);
      rchk("hold", 16'h1040, 32'h0505_0000);
      pulse();
      rchk("sw clear", 16'h1048, 32'h0, 32'hffff_fc00);
      wdt_host_i.wr(16'h1048, 32'h003f_9fe7);
      @(posedge clk) #1 bus_rst_n = 1'b0;
      repeat (5) @(posedge clk);
      rchk("bus clear", 16'h1048, 32'h0);
      bus_rst_n = 1'b1;
      repeat (3) @(posedge clk);
      wdt_host_i.wr(16'h1048, 32'h000f_9fe7);
      wdt_host_i.wr(16'h1040, 32'h0200_0001);
      repeat (300) @(posedge clk);
      rchk("count", 16'h1040, 32'h0201_0001);
      chk("irq", 32'h0, {31'h0, irq});
      wdt_host_i.wr(16'h1048, 32'h000f_9fe7);
      repeat (300) @(posedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      chk("pin", 32'h1, {31'h0, pin});
      rchk("expired", 16'h1040, 32'h0200_0001);
      wdt_host_i.wr(16'h1044, 32'h0000_0001);
      chk("irq", 32'h0, {31'h0, irq});
      rchk("status", 16'h1044, 32'h0);
      rchk("rearm", 16'h1040, 32'h0202_0001);
      wdt_host_i.wr(16'h1044, 32'h0000_0003);
      chk("irq", 32'h1, {31'h0, irq});
      rchk("forced", 16'h1040, 32'h0200_0001);
      arst_n = 1'b0;
      @(posedge clk) #1 chk("reset pin", 32'h0, {31'h0, pin});
      chk("reset irq", 32'h0, {31'h0, irq});
      arst_n = 1'b1;
      rchk("reset", 16'h1040, 32'h0202_0000);
      end_of_test();
   end
endmodule
